/* hw/regaddr_pkg.sv */
package regaddr_pkg;
  // register map in set 1
  localparam logic [7:0] slice_ptr_a_offset = 8'hd6;
  localparam logic [7:0] slice_ptr_b_offset = 8'hd7;
  localparam logic [7:0] sp_high_offset = 8'hd8;
  localparam logic [7:0] sp_low_offset = 8'hd9;
  // reset values of the slice pointers
  localparam logic [7:0] slice_ptr_a_reset = 8'hc0;
  localparam logic [7:0] slice_ptr_b_reset = 8'hc8;
  // working register escape nibble
  localparam logic [3:0] working_escape = 4'hc;
  // upper set (set 1 / set 2 duplicated range) starts here
  localparam logic [1:0] upper_set_top = 2'h3;
  // field positions
  localparam int slice_sel_bit = 3;
  localparam int slice_base_lsb = 3;
  // stack step
  localparam logic [15:0] sp_step = 16'h0001;

  // stack operations requested by execute logic
  typedef enum logic [2:0] {
    stk_idle = 3'b000,
    stk_push = 3'b001,
    stk_pop = 3'b010,
    stk_call = 3'b011,
    stk_ret = 3'b100,
    stk_int = 3'b101,
    stk_interrupt_return_op = 3'b110
  } stack_op_t;

  // stack sequencer states
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_push_lo = 3'b001,
    st_push_hi = 3'b010,
    st_push_flags = 3'b011,
    st_pop_flags = 3'b100,
    st_pop_hi = 3'b101,
    st_pop_lo = 3'b110
  } stack_state_t;
endpackage

/* hw/stack_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
// stack memory port between sequencer and top
interface stack_bus_if;
  logic wr;
  logic rd;
  logic [15:0] addr;
  logic [7:0] wdata;
  modport seq (output wr, output rd, output addr, output wdata);
  modport top (input wr, input rd, input addr, input wdata);
endinterface
`default_nettype wire

/* hw/stack_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module stack_sequencer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire regaddr_pkg::stack_op_t op,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] flags_in,
  input wire logic [7:0] data_in,
  input wire logic [7:0] mem_rdata,
  // stack pointer
  input wire logic [15:0] sp_cur,
  output logic sp_load,
  output logic [15:0] sp_value,
  // results
  output logic busy,
  output logic done,
  output logic [15:0] pc_out,
  output logic [7:0] flags_out,
  output logic [7:0] data_out,
  // memory port
  stack_bus_if.seq mem
);
  regaddr_pkg::stack_state_t state_reg, state_next;
  logic [15:0] pc_reg, pc_next;
  logic [7:0] flags_reg, flags_next;
  logic [7:0] data_reg, data_next;
  logic done_reg, done_next;
  logic rd_pend_reg, rd_pend_next;
  logic [1:0] rd_dst_reg, rd_dst_next;
  logic interrupt_return_op_reg, interrupt_return_op_next;

  function automatic logic [15:0] dec(input logic [15:0] v);
    dec = v - regaddr_pkg::sp_step; // full 16 bit borrow
  endfunction
  function automatic logic [15:0] inc(input logic [15:0] v);
    inc = v + regaddr_pkg::sp_step; // full 16 bit carry
  endfunction

  // next-state and stack pointer arithmetic
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    flags_next = flags_reg;
    data_next = data_reg;
    done_next = 1'b0;
    rd_pend_next = 1'b0;
    rd_dst_next = rd_dst_reg;
    interrupt_return_op_next = interrupt_return_op_reg;
    sp_load = 1'b0;
    sp_value = sp_cur;
    mem.wr = 1'b0;
    mem.rd = 1'b0;
    mem.addr = sp_cur;
    mem.wdata = 8'h00;
    unique case (state_reg)
      regaddr_pkg::st_idle: begin
        unique case (op)
          regaddr_pkg::stk_push: begin
            // decrement first, then write
            sp_value = dec(sp_cur);
            sp_load = 1'b1;
            mem.wr = 1'b1;
            mem.addr = dec(sp_cur);
            mem.wdata = data_in;
            done_next = 1'b1;
          end
          regaddr_pkg::stk_pop: begin
            // read at top, then increment
            mem.rd = 1'b1;
            sp_value = inc(sp_cur);
            sp_load = 1'b1;
            rd_pend_next = 1'b1;
            rd_dst_next = 2'd0;
            done_next = 1'b1;
          end
          regaddr_pkg::stk_call, regaddr_pkg::stk_int: begin
            pc_next = pc_in;
            flags_next = flags_in;
            interrupt_return_op_next = (op == regaddr_pkg::stk_int);
            state_next = regaddr_pkg::st_push_lo;
          end
          regaddr_pkg::stk_ret, regaddr_pkg::stk_interrupt_return_op: begin
            interrupt_return_op_next = (op == regaddr_pkg::stk_interrupt_return_op);
            state_next = (op == regaddr_pkg::stk_interrupt_return_op) ?
              regaddr_pkg::st_pop_flags : regaddr_pkg::st_pop_hi;
          end
          default: ;
        endcase
      end
      regaddr_pkg::st_push_lo, regaddr_pkg::st_push_hi,
      regaddr_pkg::st_push_flags: begin
        sp_value = dec(sp_cur);
        sp_load = 1'b1;
        mem.wr = 1'b1;
        mem.addr = dec(sp_cur);
        if (state_reg == regaddr_pkg::st_push_lo) begin
          mem.wdata = pc_reg[7:0];
          state_next = regaddr_pkg::st_push_hi;
        end else if (state_reg == regaddr_pkg::st_push_hi) begin
          mem.wdata = pc_reg[15:8];
          state_next = interrupt_return_op_reg ? regaddr_pkg::st_push_flags :
            regaddr_pkg::st_idle;
          done_next = !interrupt_return_op_reg;
        end else begin
          mem.wdata = flags_reg; // flags end on top
          state_next = regaddr_pkg::st_idle;
          done_next = 1'b1;
        end
      end
      regaddr_pkg::st_pop_flags, regaddr_pkg::st_pop_hi,
      regaddr_pkg::st_pop_lo: begin
        mem.rd = 1'b1;
        sp_value = inc(sp_cur);
        sp_load = 1'b1;
        rd_pend_next = 1'b1;
        if (state_reg == regaddr_pkg::st_pop_flags) begin
          rd_dst_next = 2'd1;
          state_next = regaddr_pkg::st_pop_hi;
        end else if (state_reg == regaddr_pkg::st_pop_hi) begin
          rd_dst_next = 2'd2;
          state_next = regaddr_pkg::st_pop_lo;
        end else begin
          rd_dst_next = 2'd3;
          state_next = regaddr_pkg::st_idle;
          done_next = 1'b1;
        end
      end
      default: state_next = regaddr_pkg::st_idle;
    endcase
    // memory data stands only while the read strobe is high: take it now
    if (mem.rd) begin
      unique case (rd_dst_next)
        2'd0: data_next = mem_rdata;
        2'd1: flags_next = mem_rdata;
        2'd2: pc_next[15:8] = mem_rdata;
        default: pc_next[7:0] = mem_rdata;
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= regaddr_pkg::st_idle;
      pc_reg <= 16'h0000;
      flags_reg <= 8'h00;
      data_reg <= 8'h00;
      done_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_dst_reg <= 2'd0;
      interrupt_return_op_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      flags_reg <= flags_next;
      data_reg <= data_next;
      done_reg <= done_next;
      rd_pend_reg <= rd_pend_next;
      rd_dst_reg <= rd_dst_next;
      interrupt_return_op_reg <= interrupt_return_op_next;
    end
  end

  assign busy = (state_reg != regaddr_pkg::st_idle) || rd_pend_reg;
  assign done = done_reg;
  assign pc_out = pc_reg;
  assign flags_out = flags_reg;
  assign data_out = data_reg;
endmodule // stack_sequencer
`default_nettype wire

/* hw/reg_file_addr_and_stack.sv */
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module reg_file_addr_and_stack (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // operand address generation
  input wire logic [3:0] short_field,
  input wire logic [7:0] long_operand,
  input wire logic pair_access,
  output logic [7:0] short_addr,
  output logic [7:0] long_addr,
  output logic long_is_working,
  output logic [7:0] pair_hi_addr,
  output logic [7:0] pair_lo_addr,
  output logic upper_set_select,
  // stack requests
  input wire regaddr_pkg::stack_op_t stack_op,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] flags_in,
  input wire logic [7:0] push_data,
  input wire logic [7:0] stack_rdata,
  output logic stack_busy,
  output logic stack_done,
  output logic [15:0] pc_out,
  output logic [7:0] flags_out,
  output logic [7:0] pop_data,
  // stack memory
  output logic stack_wr,
  output logic stack_rd,
  output logic [15:0] stack_addr,
  output logic [7:0] stack_wdata,
  // pointer view
  output logic [15:0] stack_top_pointer
);
  logic [7:0] working_slice_pointer_a_reg, working_slice_pointer_a_next;
  logic [7:0] working_slice_pointer_b_reg, working_slice_pointer_b_next;
  logic [7:0] stack_pointer_high_byte_reg, stack_pointer_high_byte_next;
  logic [7:0] stack_pointer_low_byte_reg, stack_pointer_low_byte_next;
  logic [7:0] rdata_reg, rdata_next;
  logic sp_load;
  logic [15:0] sp_value;
  stack_bus_if sbus ();

  // form a working register address from a 4-bit field
  function automatic logic [7:0] work_addr(input logic [3:0] fld,
    input logic [7:0] pa, input logic [7:0] pb);
    logic [7:0] ptr;
    ptr = fld[regaddr_pkg::slice_sel_bit] ? pb : pa;
    // upper five bits of pointer, low three from field
    work_addr = {ptr[7:regaddr_pkg::slice_base_lsb], fld[2:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // operand address generation
  always_comb begin
    short_addr = work_addr(short_field, working_slice_pointer_a_reg,
      working_slice_pointer_b_reg);
    long_is_working = (long_operand[7:4] == regaddr_pkg::working_escape);
    if (long_is_working) begin
      long_addr = work_addr(long_operand[3:0], working_slice_pointer_a_reg,
        working_slice_pointer_b_reg);
    end else begin
      long_addr = long_operand;
    end
    // pairs sit at even address, lsb at the odd one above
    pair_hi_addr = pair_access ? {long_addr[7:1], 1'b0} : long_addr;
    pair_lo_addr = pair_access ? {long_addr[7:1], 1'b1} : long_addr;
  end

  // register mode reaches set 1 only, never the set 2 copy
  assign upper_set_select = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // stack sequencer
  stack_sequencer u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .op(stack_op),
    .pc_in(pc_in),
    .flags_in(flags_in),
    .data_in(push_data),
    .mem_rdata(stack_rdata),
    .sp_cur(stack_top_pointer),
    .sp_load(sp_load),
    .sp_value(sp_value),
    .busy(stack_busy),
    .done(stack_done),
    .pc_out(pc_out),
    .flags_out(flags_out),
    .data_out(pop_data),
    .mem(sbus.seq)
  );

  assign stack_wr = sbus.wr;
  assign stack_rd = sbus.rd;
  assign stack_addr = sbus.addr;
  assign stack_wdata = sbus.wdata;
  // high byte at D8H, low at D9H
  assign stack_top_pointer = {stack_pointer_high_byte_reg,
    stack_pointer_low_byte_reg};

  ////////////////////////////////////////////////////////////////////////
  // register writes and reads
  always_comb begin
    working_slice_pointer_a_next = working_slice_pointer_a_reg;
    working_slice_pointer_b_next = working_slice_pointer_b_reg;
    stack_pointer_high_byte_next = stack_pointer_high_byte_reg;
    stack_pointer_low_byte_next = stack_pointer_low_byte_reg;
    rdata_next = 8'h00;
    // stack movement wins over a software write in the same cycle
    if (sp_load) begin
      stack_pointer_high_byte_next = sp_value[15:8];
      stack_pointer_low_byte_next = sp_value[7:0];
    end else if (reg_wr) begin
      unique case (reg_addr)
        regaddr_pkg::sp_high_offset: stack_pointer_high_byte_next = reg_wdata;
        regaddr_pkg::sp_low_offset: stack_pointer_low_byte_next = reg_wdata;
        default: ;
      endcase
    end
    if (reg_wr) begin
      unique case (reg_addr)
        regaddr_pkg::slice_ptr_a_offset:
          working_slice_pointer_a_next = reg_wdata;
        regaddr_pkg::slice_ptr_b_offset:
          working_slice_pointer_b_next = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        regaddr_pkg::slice_ptr_a_offset:
          rdata_next = working_slice_pointer_a_reg;
        regaddr_pkg::slice_ptr_b_offset:
          rdata_next = working_slice_pointer_b_reg;
        regaddr_pkg::sp_high_offset: rdata_next = stack_pointer_high_byte_reg;
        regaddr_pkg::sp_low_offset: rdata_next = stack_pointer_low_byte_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // pointer registers take reset values
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      working_slice_pointer_a_reg <= regaddr_pkg::slice_ptr_a_reset;
      working_slice_pointer_b_reg <= regaddr_pkg::slice_ptr_b_reset;
      rdata_reg <= 8'h00;
    end else begin
      working_slice_pointer_a_reg <= working_slice_pointer_a_next;
      working_slice_pointer_b_reg <= working_slice_pointer_b_next;
      rdata_reg <= rdata_next;
    end
  end

  // stack pointer carries no reset value
  always_ff @(posedge clk) begin
    stack_pointer_high_byte_reg <= stack_pointer_high_byte_next;
    stack_pointer_low_byte_reg <= stack_pointer_low_byte_next;
  end

  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence push_step_s;
    stack_wr && !stack_rd;
  endsequence

  short_slice_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    short_addr == (short_field[3] ?
    {working_slice_pointer_b_reg[7:3], short_field[2:0]} :
    {working_slice_pointer_a_reg[7:3], short_field[2:0]}))
    else $error("short address wrong slice");
  short_low_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    short_addr[2:0] == short_field[2:0])
    else $error("short address low bits wrong");
  long_escape_a: assert property (@(posedge clk) disable iff (!rst_n)
    (long_operand[7:4] == 4'hc) |-> long_addr[2:0] == long_operand[2:0] &&
    long_addr[7:3] == (long_operand[3] ? working_slice_pointer_b_reg[7:3] :
    working_slice_pointer_a_reg[7:3]))
    else $error("escape operand not resolved");
  pair_even_a: assert property (@(posedge clk) disable iff (!rst_n)
    pair_access |-> !pair_hi_addr[0] && pair_lo_addr == pair_hi_addr + 8'h01)
    else $error("pair not even and odd");
  reset_ptrs_a: assert property (@(posedge clk)
    !rst_n |=> working_slice_pointer_a_reg == 8'hc0 &&
    working_slice_pointer_b_reg == 8'hc8)
    else $error("pointer reset value wrong");
  push_pre_dec_a: assert property (@(posedge clk) disable iff (!rst_n)
    push_step_s |-> stack_addr == stack_top_pointer - 16'h0001 ##1
    stack_top_pointer == $past(stack_addr))
    else $error("push not pre-decremented");
  pop_post_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
    stack_rd |-> stack_addr == stack_top_pointer ##1
    stack_top_pointer == $past(stack_addr) + 16'h0001)
    else $error("pop not post-incremented");
  call_sequence_a: assert property (@(posedge clk) disable iff (!rst_n)
    (stack_op == regaddr_pkg::stk_call && !stack_busy && !stack_done)
    |=> stack_wr [*2] ##1 !stack_wr)
    else $error("call did not push two bytes");
  int_sequence_a: assert property (@(posedge clk) disable iff (!rst_n)
    (stack_op == regaddr_pkg::stk_int && !stack_busy && !stack_done)
    |=> stack_wr [*3] ##1 !stack_wr)
    else $error("interrupt entry did not push three bytes");
endmodule // reg_file_addr_and_stack
`default_nettype wire

/* tb/stack_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// stack memory beside the block, combinational read as the block expects
module stack_mem_model (
  // clock
  input wire logic clk,
  // memory port
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:255];
  logic [7:0] last_reg;

  ////////////////////////////////////////////////////////////////////////////
  // only the internal register file exists, so the low byte picks the cell
  always @(posedge clk) begin
    if (wr) begin
      mem[addr[7:0]] <= wdata;
    end
    if (rd) begin
      last_reg <= mem[addr[7:0]];
    end
  end

  // outside a read the data lines show the inverse of the last read value, not the last one
  assign rdata = rd ? mem[addr[7:0]] : ~last_reg;
endmodule // stack_mem_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst_n, reg_wr, reg_rd, pair_access;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, long_operand, flags_in;
  logic [7:0] push_data, stack_rdata, flags_out, pop_data, stack_wdata;
  logic [7:0] short_addr, long_addr, pair_hi_addr, pair_lo_addr, pa, pb, rv;
  logic [3:0] short_field;
  logic long_is_working, upper_set_select, stack_busy, stack_done;
  logic stack_wr, stack_rd;
  logic [15:0] pc_in, pc_out, stack_addr, stack_top_pointer;
  regaddr_pkg::stack_op_t stack_op;
  int n_tests, n_mismatch;

  ////////////////////////////////////////////////////////////////////////////
  // block and its stack memory
  reg_file_addr_and_stack uut (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .short_field(short_field),
    .long_operand(long_operand), .pair_access(pair_access),
    .short_addr(short_addr), .long_addr(long_addr),
    .long_is_working(long_is_working), .pair_hi_addr(pair_hi_addr),
    .pair_lo_addr(pair_lo_addr), .upper_set_select(upper_set_select),
    .stack_op(stack_op), .pc_in(pc_in), .flags_in(flags_in),
    .push_data(push_data), .stack_rdata(stack_rdata),
    .stack_busy(stack_busy), .stack_done(stack_done), .pc_out(pc_out),
    .flags_out(flags_out), .pop_data(pop_data), .stack_wr(stack_wr),
    .stack_rd(stack_rd), .stack_addr(stack_addr),
    .stack_wdata(stack_wdata), .stack_top_pointer(stack_top_pointer));

  stack_mem_model mem_i (.clk(clk), .wr(stack_wr), .rd(stack_rd),
    .addr(stack_addr), .wdata(stack_wdata), .rdata(stack_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // hang guard at 6000 cycles, several times the roughly 1100 cycles the tests need
  initial begin
    #(25 * 6000);
    n_mismatch++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one-cycle write strobe
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // one stack request, then idle until the completion pulse
  task automatic stk(input regaddr_pkg::stack_op_t op,
                     input logic [15:0] pc, input logic [7:0] fl,
                     input logic [7:0] d);
    int k;
    @(posedge clk);
    stack_op <= op;
    pc_in <= pc;
    flags_in <= fl;
    push_data <= d;
    @(posedge clk);
    stack_op <= regaddr_pkg::stk_idle;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (stack_done !== 1'b1 && k < 20);
    check(stack_done, 1'b1);
  endtask

  // working register address expected from the two pointers
  function automatic logic [7:0] wk(input logic [3:0] f);
    wk = {(f[3] ? pb[7:3] : pa[7:3]), f[2:0]};
  endfunction

  // every operand value, with and without pair access
  task automatic addr_sweep();
    logic [7:0] e;
    for (int i = 0; i < 512; i++) begin
      @(posedge clk);
      long_operand <= i[7:0]; // common area only in working form
      pair_access <= i[8];
      short_field <= i[3:0];
      @(negedge clk);
      e = (i[7:4] == regaddr_pkg::working_escape) ? wk(i[3:0]) : i[7:0];
      check(short_addr, wk(i[3:0]));
      check(long_addr, e);
      check(long_is_working, i[7:4] == 4'hc);
      check(upper_set_select, 1'b0);
      check(pair_hi_addr, i[8] ? {e[7:1], 1'b0} : e);
      check(pair_lo_addr, i[8] ? {e[7:1], 1'b1} : e);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    n_tests = 0;
    n_mismatch = 0;
    rst_n = 1'b0;
    {reg_wr, reg_rd, pair_access} = 3'b000;
    {reg_addr, reg_wdata, long_operand, flags_in, push_data} = '0;
    short_field = 4'h0;
    pc_in = 16'h0000;
    stack_op = regaddr_pkg::stk_idle;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // pointer reset values and an unmapped address
    reg_read(regaddr_pkg::slice_ptr_a_offset, rv);
    check(rv, 8'hc0);
    reg_read(regaddr_pkg::slice_ptr_b_offset, rv);
    check(rv, 8'hc8);
    reg_read(8'h40, rv);
    check(rv, 8'h00);
    pa = 8'hc0;
    pb = 8'hc8;
    addr_sweep();
    // low pointer bits set so that they must be ignored
    pa = 8'h77;
    pb = 8'hab;
    reg_write(regaddr_pkg::slice_ptr_a_offset, pa);
    reg_write(regaddr_pkg::slice_ptr_b_offset, pb);
    reg_write(8'h40, 8'h99);
    reg_read(8'h40, rv);
    check(rv, 8'h00);
    addr_sweep();
    // push with a borrow out of the low byte
    reg_write(8'hd8, 8'h12);
    reg_write(8'hd9, 8'h00);
    check(stack_top_pointer, 16'h1200);
    stk(regaddr_pkg::stk_push, 16'h0000, 8'h00, 8'h5a);
    check(stack_top_pointer, 16'h11ff);
    check(mem_i.mem[8'hff], 8'h5a);
    reg_read(8'hd8, rv);
    check(rv, 8'h11);
    reg_read(8'hd9, rv);
    check(rv, 8'hff);
    stk(regaddr_pkg::stk_pop, 16'h0000, 8'h00, 8'h00);
    check(pop_data, 8'h5a);
    check(stack_top_pointer, 16'h1200);
    // low byte started at ff, the way software should set it up
    reg_write(8'hd8, 8'h00);
    reg_write(8'hd9, 8'hff);
    // two pushes back to back, popped in reverse order
    stk(regaddr_pkg::stk_push, 16'h0000, 8'h00, 8'h11);
    stk(regaddr_pkg::stk_push, 16'h0000, 8'h00, 8'h22);
    check(stack_top_pointer, 16'h00fd);
    stk(regaddr_pkg::stk_pop, 16'h0000, 8'h00, 8'h00);
    check(pop_data, 8'h22);
    stk(regaddr_pkg::stk_pop, 16'h0000, 8'h00, 8'h00);
    check(pop_data, 8'h11);
    // call and return
    stk(regaddr_pkg::stk_call, 16'hbeef, 8'h00, 8'h00);
    check(stack_top_pointer, 16'h00fd);
    check(mem_i.mem[8'hfe], 8'hef);
    check(mem_i.mem[8'hfd], 8'hbe);
    stk(regaddr_pkg::stk_ret, 16'h0000, 8'h00, 8'h00);
    check(pc_out, 16'hbeef);
    check(stack_top_pointer, 16'h00ff);
    // interrupt entry and return
    stk(regaddr_pkg::stk_int, 16'h1234, 8'ha5, 8'h00);
    check(stack_top_pointer, 16'h00fc);
    check(mem_i.mem[8'hfc], 8'ha5);
    check(mem_i.mem[8'hfd], 8'h12);
    check(mem_i.mem[8'hfe], 8'h34);
    stk(regaddr_pkg::stk_interrupt_return_op, 16'h0000, 8'h00, 8'h00);
    check(pc_out, 16'h1234);
    check(flags_out, 8'ha5);
    check(stack_top_pointer, 16'h00ff);
    end_sim();
  end
endmodule // tb
`default_nettype wire
